// file: design/fcs_cfg.svh
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH
`define FCS_CLK_PERIOD_NS   5
`define FCS_PROG_TIME_NS    40000
`define FCS_PROG_CYCLES     (`FCS_PROG_TIME_NS / `FCS_CLK_PERIOD_NS)
`define FCS_ERASE_TIME_NS   30000000
`define FCS_ERASE_CYCLES    (`FCS_ERASE_TIME_NS / `FCS_CLK_PERIOD_NS)
`define FCS_UNLOCK_ENABLE   4'h3
`define FCS_UNLOCK_RESET    4'hC
`define FCS_ADR_UNLOCK1     12'h555
`define FCS_ADR_UNLOCK2     12'hAAA
`define FCS_DAT_UNLOCK1     8'hAA
`define FCS_DAT_UNLOCK2     8'h55
`define FCS_CMD_PROGRAM     8'hA0
`define FCS_CMD_ERASE       8'h80
`define FCS_CMD_ID_ENTRY    8'h90
`define FCS_CMD_PROTECT     8'hA5
`define FCS_CMD_ID_EXIT     8'hF0
`define FCS_CMD_SECTOR      8'h30
`define FCS_CMD_CHIP        8'h10
`define FCS_CMD_AREA        4'hF
`define FCS_ID_MAKER_ADR    16'hF000
`define FCS_ID_MACRO_ADR    16'hF001
`define FCS_ID_SIZE_ADR     16'hF002
`define FCS_PROTECT_ADR     16'hFF7F
`define FCS_PROTECT_DAT     8'h00
`define FCS_PROT_ON_VALUE   8'h00
`define FCS_ERASED          8'hFF
`define FCS_REFUSED_DAT     8'h00
`define FCS_TOGGLE_BIT      6
`define FCS_ARRAY_KB        16
`define FCS_SECTOR_SHIFT    12
`define FCS_MAKER_CODE      8'h5A
`define FCS_MACRO_CODE      8'h3C
`define FCS_SIZE_60         8'h0E
`define FCS_SIZE_48         8'h0B
`define FCS_SIZE_32         8'h07
`define FCS_SIZE_24         8'h05
`define FCS_SIZE_16         8'h03
`define FCS_SIZE_8          8'h01
`define FCS_SIZE_4          8'h00
`endif

// file: design/fcs_pkg.sv
package fcs_pkg;
  typedef enum logic [1:0] {FCS_MODE_MCU, FCS_MODE_SERIAL, FCS_MODE_PARALLEL} fcs_mode_t;
  typedef enum logic [2:0] {FCS_SQ_IDLE, FCS_SQ_U1, FCS_SQ_U2, FCS_SQ_PROG, FCS_SQ_E1, FCS_SQ_E2, FCS_SQ_E3,
                            FCS_SQ_PROT} fcs_seq_t;
  typedef enum logic [2:0] {FCS_JOB_NONE, FCS_JOB_PROG, FCS_JOB_SECTOR, FCS_JOB_CHIP, FCS_JOB_PROTECT} fcs_job_t;
  typedef enum logic [2:0] {FCS_OP_READ, FCS_OP_PROGRAM, FCS_OP_SECTOR_ERASE, FCS_OP_CHIP_ERASE, FCS_OP_ID_ENTRY,
                            FCS_OP_ID_EXIT, FCS_OP_PROTECT} fcs_cmd_t;
  typedef enum logic [2:0] {FCS_H_IDLE, FCS_H_WRITE, FCS_H_POLL, FCS_H_READ} fcs_host_st_t;
endpackage : fcs_pkg

// file: design/fcs_bus_if.sv
`timescale 1ns/1ps
interface fcs_bus_if;
  logic        req;
  logic        we;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        rvalid;
  modport dev (input req, input we, input addr, input wdata, output rdata, output rvalid);
  modport cpu (output req, output we, output addr, output wdata, input rdata, input rvalid);
endinterface : fcs_bus_if

// file: design/fcs_flash_dev.sv
`timescale 1ns/1ps
`include "fcs_cfg.svh"
module fcs_flash_dev #(
  parameter int ARRAY_KB     = `FCS_ARRAY_KB,
  parameter int PROG_CYCLES  = `FCS_PROG_CYCLES,
  parameter int ERASE_CYCLES = `FCS_ERASE_CYCLES
) (
  input  wire logic              i_sys_clk,      // System clock
  input  wire logic              i_reset_n,      // Async reset, active low
  fcs_bus_if.dev                 bus,            // Memory bus from the CPU
  input  wire logic [3:0]        i_unlock_field, // command_unlock_field of flash_control_reg
  input  wire fcs_pkg::fcs_mode_t i_prog_mode,   // Programming mode
  output logic                   o_busy,         // Timed operation in progress
  output logic                   o_read_protect, // Read protection set
  output logic                   o_id_mode       // Identification mode active
);
  localparam int ARRAY_BYTES = ARRAY_KB * 1024;
  localparam int AW          = $clog2(ARRAY_BYTES);
  localparam int TW          = 23;
  localparam logic [15:0] BASE = 16'(32'h10000 - ARRAY_BYTES);
  localparam logic [AW:0] SECTOR_BYTES = (AW + 1)'(1 << `FCS_SECTOR_SHIFT);
  localparam logic [AW:0] ALL_BYTES    = (AW + 1)'(ARRAY_BYTES);

  typedef struct packed {
    fcs_pkg::fcs_seq_t seq;
    fcs_pkg::fcs_job_t job;
    logic [TW-1:0]     timer;
    logic [AW-1:0]     wipe_idx;
    logic [AW:0]       wipe_left;
    logic [AW-1:0]     tgt_idx;
    logic [7:0]        tgt_data;
    logic              id_mode;
    logic              protect;
    logic              toggle;
    logic              busy;
    logic              rvalid;
    logic [7:0]        rdata;
  } fcs_dev_state_t;

  fcs_dev_state_t st;
  fcs_dev_state_t next_st;
  logic [7:0]     mem [ARRAY_BYTES];
  logic           mem_we;
  logic [AW-1:0]  mem_idx;
  logic [7:0]     mem_dat;

  function automatic logic [7:0] size_code(input int kb);
    case (kb)
      60:      size_code = `FCS_SIZE_60;
      48:      size_code = `FCS_SIZE_48;
      32:      size_code = `FCS_SIZE_32;
      24:      size_code = `FCS_SIZE_24;
      16:      size_code = `FCS_SIZE_16;
      8:       size_code = `FCS_SIZE_8;
      default: size_code = `FCS_SIZE_4;
    endcase
  endfunction : size_code

  always_comb begin
    logic [11:0]   a12;
    logic          in_arr;
    logic [AW-1:0] idx;
    logic [7:0]    rd;
    logic          wr_ok;
    a12     = bus.addr[11:0];
    in_arr  = bus.addr >= BASE;
    idx     = AW'(bus.addr - BASE);
    rd      = `FCS_REFUSED_DAT;
    wr_ok   = bus.req && bus.we && !st.busy && (i_unlock_field == `FCS_UNLOCK_ENABLE);
    next_st = st;
    next_st.rvalid = 1'b0;
    mem_we  = 1'b0;
    mem_idx = '0;
    mem_dat = '0;

    // Erase walks one byte per cycle; the timer always outlasts the walk
    if (st.job != fcs_pkg::FCS_JOB_NONE) begin
      if (st.wipe_left != '0) begin
        mem_we = 1'b1;
        mem_idx = st.wipe_idx;
        mem_dat = `FCS_ERASED;
        next_st.wipe_idx  = st.wipe_idx + 1'b1;
        next_st.wipe_left = st.wipe_left - 1'b1;
      end
      if (st.timer == '0) begin
        case (st.job)
          fcs_pkg::FCS_JOB_PROG: begin
            mem_we  = 1'b1;
            mem_idx = st.tgt_idx;
            mem_dat = mem[st.tgt_idx] & st.tgt_data;
          end
          fcs_pkg::FCS_JOB_PROTECT: next_st.protect = 1'b1;
          fcs_pkg::FCS_JOB_CHIP:    next_st.protect = 1'b0;
          default: ;
        endcase
        next_st.job  = fcs_pkg::FCS_JOB_NONE;
        next_st.busy = 1'b0;
      end else begin
        next_st.timer = st.timer - 1'b1;
      end
    end

    if (bus.req && !bus.we) begin
      if (st.busy) begin
        rd = in_arr ? mem[idx] : `FCS_REFUSED_DAT;
        rd[`FCS_TOGGLE_BIT] = st.toggle;
        next_st.toggle = ~st.toggle;
      end else if (st.id_mode) begin
        case (bus.addr)
          `FCS_ID_MAKER_ADR: rd = `FCS_MAKER_CODE;
          `FCS_ID_MACRO_ADR: rd = `FCS_MACRO_CODE;
          `FCS_ID_SIZE_ADR:  rd = size_code(ARRAY_KB);
          `FCS_PROTECT_ADR:  rd = st.protect ? `FCS_PROT_ON_VALUE : `FCS_ERASED;
          default:           rd = `FCS_REFUSED_DAT;
        endcase
      end else if (in_arr && !(st.protect && i_prog_mode == fcs_pkg::FCS_MODE_PARALLEL)) begin
        rd = mem[idx];
      end
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd;
    end

    if (wr_ok) begin
      next_st.seq = fcs_pkg::FCS_SQ_IDLE;
      case (st.seq)
        fcs_pkg::FCS_SQ_IDLE: begin
          if (a12 == `FCS_ADR_UNLOCK1 && bus.wdata == `FCS_DAT_UNLOCK1) begin
            next_st.seq = fcs_pkg::FCS_SQ_U1;
          end else if (bus.wdata == `FCS_CMD_ID_EXIT) begin
            next_st.id_mode = 1'b0;
          end
        end
        fcs_pkg::FCS_SQ_U1: begin
          if (a12 == `FCS_ADR_UNLOCK2 && bus.wdata == `FCS_DAT_UNLOCK2) begin
            next_st.seq = fcs_pkg::FCS_SQ_U2;
          end
        end
        fcs_pkg::FCS_SQ_U2: begin
          if (a12 == `FCS_ADR_UNLOCK1) begin
            case (bus.wdata)
              `FCS_CMD_PROGRAM:  next_st.seq = fcs_pkg::FCS_SQ_PROG;
              `FCS_CMD_ERASE:    next_st.seq = fcs_pkg::FCS_SQ_E1;
              `FCS_CMD_PROTECT:  next_st.seq = fcs_pkg::FCS_SQ_PROT;
              `FCS_CMD_ID_ENTRY: next_st.id_mode = 1'b1;
              `FCS_CMD_ID_EXIT:  next_st.id_mode = 1'b0;
              default: ;
            endcase
          end
        end
        fcs_pkg::FCS_SQ_PROG: begin
          if (in_arr && !(st.protect && i_prog_mode == fcs_pkg::FCS_MODE_SERIAL)) begin
            next_st.job      = fcs_pkg::FCS_JOB_PROG;
            next_st.tgt_idx  = idx;
            next_st.tgt_data = bus.wdata;
            next_st.timer    = TW'(PROG_CYCLES - 1);
            next_st.busy     = 1'b1;
            next_st.toggle   = 1'b1;
          end
        end
        fcs_pkg::FCS_SQ_E1: begin
          if (a12 == `FCS_ADR_UNLOCK1 && bus.wdata == `FCS_DAT_UNLOCK1) begin
            next_st.seq = fcs_pkg::FCS_SQ_E2;
          end
        end
        fcs_pkg::FCS_SQ_E2: begin
          if (a12 == `FCS_ADR_UNLOCK2 && bus.wdata == `FCS_DAT_UNLOCK2) begin
            next_st.seq = fcs_pkg::FCS_SQ_E3;
          end
        end
        fcs_pkg::FCS_SQ_E3: begin
          if (bus.wdata == `FCS_CMD_SECTOR && in_arr && i_prog_mode != fcs_pkg::FCS_MODE_PARALLEL) begin
            next_st.job       = fcs_pkg::FCS_JOB_SECTOR;
            next_st.wipe_idx  = AW'({bus.addr[15:`FCS_SECTOR_SHIFT], 12'h000} - BASE);
            next_st.wipe_left = SECTOR_BYTES;
            next_st.timer     = TW'(ERASE_CYCLES - 1);
            next_st.busy      = 1'b1;
            next_st.toggle    = 1'b1;
          end else if (bus.wdata == `FCS_CMD_CHIP && a12 == `FCS_ADR_UNLOCK1) begin
            next_st.job       = fcs_pkg::FCS_JOB_CHIP;
            next_st.wipe_idx  = '0;
            next_st.wipe_left = ALL_BYTES;
            next_st.timer     = TW'(ERASE_CYCLES - 1);
            next_st.busy      = 1'b1;
            next_st.toggle    = 1'b1;
          end
        end
        fcs_pkg::FCS_SQ_PROT: begin
          if (bus.addr == `FCS_PROTECT_ADR && bus.wdata == `FCS_PROTECT_DAT) begin
            next_st.job    = fcs_pkg::FCS_JOB_PROTECT;
            next_st.timer  = TW'(PROG_CYCLES - 1);
            next_st.busy   = 1'b1;
            next_st.toggle = 1'b1;
          end
        end
        default: next_st.seq = fcs_pkg::FCS_SQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Array has no reset: contents are undefined until erased
  always_ff @(posedge i_sys_clk) begin
    if (mem_we) begin
      mem[mem_idx] <= mem_dat;
    end
  end

  assign bus.rdata      = st.rdata;
  assign bus.rvalid     = st.rvalid;
  assign o_busy         = st.busy;
  assign o_read_protect = st.protect;
  assign o_id_mode      = st.id_mode;
endmodule : fcs_flash_dev

// file: design/fcs_flash_host.sv
`timescale 1ns/1ps
`include "fcs_cfg.svh"
module fcs_flash_host (
  input  wire logic              i_sys_clk,   // System clock
  input  wire logic              i_reset_n,   // Async reset, active low
  fcs_bus_if.cpu                 bus,         // Memory bus to the flash
  input  wire logic              i_cmd_valid, // Command request
  input  wire fcs_pkg::fcs_cmd_t i_cmd_op,    // Command kind
  input  wire logic [15:0]       i_cmd_addr,  // Target address
  input  wire logic [7:0]        i_cmd_data,  // Byte to program
  output logic                   o_cmd_ready, // Ready for a command
  output logic                   o_done,      // Command finished, one cycle
  output logic [7:0]             o_rdata      // Last read or poll value
);
  typedef struct packed {
    fcs_pkg::fcs_host_st_t state;
    fcs_pkg::fcs_cmd_t     op;
    logic [15:0]           addr;
    logic [7:0]            data;
    logic [2:0]            step;
    logic                  first;
    logic                  req;
    logic                  we;
    logic [15:0]           baddr;
    logic [7:0]            bwdata;
    logic                  ready;
    logic                  done;
    logic [7:0]            rdata;
  } fcs_host_state_t;

  fcs_host_state_t st;
  fcs_host_state_t next_st;

  function automatic logic [2:0] seq_len(input fcs_pkg::fcs_cmd_t op);
    case (op)
      fcs_pkg::FCS_OP_PROGRAM, fcs_pkg::FCS_OP_PROTECT:         seq_len = 3'h4;
      fcs_pkg::FCS_OP_SECTOR_ERASE, fcs_pkg::FCS_OP_CHIP_ERASE: seq_len = 3'h6;
      fcs_pkg::FCS_OP_READ:                                     seq_len = 3'h0;
      default:                                                  seq_len = 3'h3;
    endcase
  endfunction : seq_len

  // Builds {address, data} of one write of the sequence
  function automatic logic [23:0] seq_step(input fcs_pkg::fcs_cmd_t op, input logic [2:0] n,
                                           input logic [15:0] a, input logic [7:0] d);
    logic [15:0] u1;
    logic [15:0] u2;
    logic [7:0]  cmd;
    u1 = {`FCS_CMD_AREA, `FCS_ADR_UNLOCK1};
    u2 = {`FCS_CMD_AREA, `FCS_ADR_UNLOCK2};
    case (op)
      fcs_pkg::FCS_OP_PROGRAM:  cmd = `FCS_CMD_PROGRAM;
      fcs_pkg::FCS_OP_ID_ENTRY: cmd = `FCS_CMD_ID_ENTRY;
      fcs_pkg::FCS_OP_ID_EXIT:  cmd = `FCS_CMD_ID_EXIT;
      fcs_pkg::FCS_OP_PROTECT:  cmd = `FCS_CMD_PROTECT;
      default:                  cmd = `FCS_CMD_ERASE;
    endcase
    case (n)
      3'h0:    seq_step = {u1, `FCS_DAT_UNLOCK1};
      3'h1:    seq_step = {u2, `FCS_DAT_UNLOCK2};
      3'h2:    seq_step = {u1, cmd};
      3'h3: begin
        if (op == fcs_pkg::FCS_OP_PROGRAM) begin
          seq_step = {a, d};
        end else if (op == fcs_pkg::FCS_OP_PROTECT) begin
          seq_step = {`FCS_PROTECT_ADR, `FCS_PROTECT_DAT};
        end else begin
          seq_step = {u1, `FCS_DAT_UNLOCK1};
        end
      end
      3'h4:    seq_step = {u2, `FCS_DAT_UNLOCK2};
      default: seq_step = (op == fcs_pkg::FCS_OP_SECTOR_ERASE) ? {a, `FCS_CMD_SECTOR} : {u1, `FCS_CMD_CHIP};
    endcase
  endfunction : seq_step

  always_comb begin
    logic [23:0] wr;
    logic [2:0]  len;
    wr  = seq_step(st.op, st.step, st.addr, st.data);
    len = seq_len(st.op);
    next_st = st;
    next_st.req  = 1'b0;
    next_st.we   = 1'b0;
    next_st.done = 1'b0;
    case (st.state)
      fcs_pkg::FCS_H_IDLE: begin
        next_st.ready = 1'b1;
        // Caller is expected to erase before programming a byte again
        if (i_cmd_valid && st.ready) begin
          next_st.ready = 1'b0;
          next_st.op    = i_cmd_op;
          next_st.addr  = i_cmd_addr;
          next_st.data  = i_cmd_data;
          next_st.step  = 3'h0;
          next_st.state = (i_cmd_op == fcs_pkg::FCS_OP_READ) ? fcs_pkg::FCS_H_READ : fcs_pkg::FCS_H_WRITE;
          if (i_cmd_op == fcs_pkg::FCS_OP_READ) begin
            next_st.req   = 1'b1;
            next_st.baddr = i_cmd_addr;
          end
        end
      end
      fcs_pkg::FCS_H_WRITE: begin
        if (st.step == len) begin
          if (st.op == fcs_pkg::FCS_OP_ID_ENTRY || st.op == fcs_pkg::FCS_OP_ID_EXIT) begin
            next_st.done  = 1'b1;
            next_st.state = fcs_pkg::FCS_H_IDLE;
          end else begin
            // Poll one address until two reads match; no array fetch meanwhile
            next_st.req   = 1'b1;
            next_st.baddr = (st.op == fcs_pkg::FCS_OP_PROGRAM) ? st.addr : {`FCS_CMD_AREA, `FCS_ADR_UNLOCK1};
            next_st.first = 1'b1;
            next_st.state = fcs_pkg::FCS_H_POLL;
          end
        end else begin
          next_st.req    = 1'b1;
          next_st.we     = 1'b1;
          next_st.baddr  = wr[23:8];
          next_st.bwdata = wr[7:0];
          next_st.step   = st.step + 3'h1;
        end
      end
      fcs_pkg::FCS_H_POLL: begin
        if (bus.rvalid) begin
          next_st.rdata = bus.rdata;
          next_st.first = 1'b0;
          if (!st.first && bus.rdata == st.rdata) begin
            next_st.done  = 1'b1;
            next_st.state = fcs_pkg::FCS_H_IDLE;
          end else begin
            next_st.req = 1'b1;
          end
        end
      end
      fcs_pkg::FCS_H_READ: begin
        if (bus.rvalid) begin
          next_st.rdata = bus.rdata;
          next_st.done  = 1'b1;
          next_st.state = fcs_pkg::FCS_H_IDLE;
        end
      end
      default: next_st.state = fcs_pkg::FCS_H_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus.req     = st.req;
  assign bus.we      = st.we;
  assign bus.addr    = st.baddr;
  assign bus.wdata   = st.bwdata;
  assign o_cmd_ready = st.ready;
  assign o_done      = st.done;
  assign o_rdata     = st.rdata;
endmodule : fcs_flash_host

// file: verification/fcs_flash_sva.sv
`timescale 1ns/1ps
module fcs_flash_sva #(
  parameter int PROG_CYCLES  = 20,
  parameter int ERASE_CYCLES = 5000
) (
  input wire logic        i_sys_clk,      // Clock
  input wire logic        i_reset_n,      // Reset, active low
  input wire logic        req,            // Bus request
  input wire logic        we,             // Write strobe
  input wire logic [15:0] addr,           // Bus address
  input wire logic [7:0]  wdata,          // Write byte
  input wire logic [7:0]  rdata,          // Read byte
  input wire logic        rvalid,         // Read answer
  input wire logic [3:0]  i_unlock_field, // Unlock field
  input wire logic        o_busy,         // Operation running
  input wire logic        o_read_protect, // Protection set
  input wire logic        o_id_mode       // ID mode active
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  int   busy_len;
  logic rd_pend;
  logic rd_first;
  logic tog_first;
  logic tog_prev;
  // Busy length is counted here so one check covers both program and erase timings
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      busy_len  <= 0;
      rd_pend   <= 1'b0;
      rd_first  <= 1'b0;
      tog_first <= 1'b1;
      tog_prev  <= 1'b0;
    end else begin
      busy_len <= o_busy ? busy_len + 1 : 0;
      rd_pend  <= o_busy && req && !we;
      if (o_busy && req && !we) begin
        rd_first  <= tog_first;
        tog_first <= 1'b0;
      end else if (!o_busy) begin
        tog_first <= 1'b1;
      end
      if (rd_pend) begin
        tog_prev <= rdata[6];
      end
    end
  end
  chk_read_answer: assert property (req && !we |=> rvalid)
    else $error("read got no answer");
  chk_first_toggle: assert property (rd_pend && rd_first |-> rvalid && rdata[6])
    else $error("first poll read lacks toggle bit");
  chk_toggle_flip: assert property (rd_pend && !rd_first |-> rdata[6] == !tog_prev)
    else $error("toggle bit did not invert");
  chk_busy_length: assert property ($fell(o_busy) |-> busy_len == PROG_CYCLES || busy_len == ERASE_CYCLES)
    else $error("busy span has wrong length");
  chk_busy_bound: assert property (busy_len <= ERASE_CYCLES)
    else $error("busy span too long");
  chk_busy_cause: assert property ($rose(o_busy) |-> $past(req && we))
    else $error("busy rose without a write");
  chk_locked_ignored: assert property (req && we && !o_busy && i_unlock_field != 4'h3 |=> !o_busy)
    else $error("locked write started an operation");
  chk_gap_after_busy: assert property ($fell(o_busy) |-> !o_busy [*4])
    else $error("operation restarted too soon");
  chk_protect_set: assert property ($rose(o_read_protect) |-> $fell(o_busy) && busy_len == PROG_CYCLES)
    else $error("protection set at wrong moment");
  chk_protect_clear: assert property ($fell(o_read_protect) |-> $fell(o_busy) && busy_len == ERASE_CYCLES)
    else $error("protection cleared without chip erase");
  chk_id_entry: assert property ($rose(o_id_mode) |-> $past(req && we && addr[11:0] == 12'h555 && wdata == 8'h90))
    else $error("ID mode entered without command");
  chk_id_exit: assert property ($fell(o_id_mode) |-> $past(req && we && wdata == 8'hF0))
    else $error("ID mode left without exit");
  cover property ($fell(o_busy) && busy_len == ERASE_CYCLES);
  cover property ($rose(o_read_protect));
  cover property ($rose(o_id_mode));
  cover property (rd_pend && !rd_first);
endmodule : fcs_flash_sva

// file: verification/tb_flash_command_sequencer.sv
`timescale 1ns/1ps
`include "fcs_cfg.svh"
module tb_flash_command_sequencer;
  localparam int PROG_CYCLES  = 20;
  localparam int ERASE_CYCLES = 5000;
  logic               i_sys_clk  = 1'b0;
  logic               i_reset_n  = 1'b0;
  logic               cmd_valid  = 1'b0;
  fcs_pkg::fcs_cmd_t  cmd_op     = fcs_pkg::FCS_OP_READ;
  logic [15:0]        cmd_addr   = 16'h0000;
  logic [7:0]         cmd_data   = 8'h00;
  logic [3:0]         unlock     = `FCS_UNLOCK_RESET;
  fcs_pkg::fcs_mode_t mode       = fcs_pkg::FCS_MODE_MCU;
  logic               ready, done, busy, prot, idm, busy_b;
  logic [7:0]         host_rdata;
  logic [15:0]        a;
  logic [31:0]        seed       = 32'd64808;
  logic [7:0]         mem [int];
  bit                 m_prot, m_id;
  int                 num_errors = 0;
  int                 samples_checked = 0;
  logic [15:0]        id_adr [4] = '{`FCS_ID_MAKER_ADR, `FCS_ID_MACRO_ADR, `FCS_ID_SIZE_ADR, `FCS_PROTECT_ADR};
  fcs_bus_if bus ();
  fcs_bus_if bus_b ();
  always #2.5 i_sys_clk = ~i_sys_clk;
  fcs_flash_dev #(.ARRAY_KB(4), .PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_fcs_flash_dev (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .bus(bus), .i_unlock_field(unlock), .i_prog_mode(mode),
    .o_busy(busy), .o_read_protect(prot), .o_id_mode(idm));
  // Second device faces the bench directly so sequences can be broken on purpose
  fcs_flash_dev #(.ARRAY_KB(4), .PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_fcs_flash_dev_b (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .bus(bus_b), .i_unlock_field(unlock), .i_prog_mode(mode),
    .o_busy(busy_b), .o_read_protect(), .o_id_mode());
  fcs_flash_host u_fcs_flash_host (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .bus(bus), .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op),
    .i_cmd_addr(cmd_addr), .i_cmd_data(cmd_data), .o_cmd_ready(ready), .o_done(done), .o_rdata(host_rdata));
  fcs_flash_sva #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_fcs_flash_sva (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .req(bus.req), .we(bus.we), .addr(bus.addr),
    .wdata(bus.wdata), .rdata(bus.rdata), .rvalid(bus.rvalid), .i_unlock_field(unlock), .o_busy(busy),
    .o_read_protect(prot), .o_id_mode(idm));
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : rnd
  function automatic logic [7:0] exp_rd(input logic [15:0] x);
    if (m_id) begin
      case (x)
        `FCS_ID_MAKER_ADR: return `FCS_MAKER_CODE;
        `FCS_ID_MACRO_ADR: return `FCS_MACRO_CODE;
        `FCS_ID_SIZE_ADR:  return `FCS_SIZE_4;
        `FCS_PROTECT_ADR:  return m_prot ? `FCS_PROT_ON_VALUE : `FCS_ERASED;
        default:           return 8'h00;
      endcase
    end
    if (x < 16'hF000 || (m_prot && mode == fcs_pkg::FCS_MODE_PARALLEL)) return 8'h00;
    return mem[x];
  endfunction : exp_rd
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic test_done();
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  task automatic host(input fcs_pkg::fcs_cmd_t op, input logic [15:0] x, input logic [7:0] d);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 100) begin
      @(negedge i_sys_clk);
      n++;
    end
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = x;
    cmd_data = d;
    @(negedge i_sys_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20000) begin
      @(negedge i_sys_clk);
      n++;
    end
    if (done !== 1'b1) check(8'h00, 8'hFF);
  endtask : host
  task automatic hrd(input logic [15:0] x);
    host(fcs_pkg::FCS_OP_READ, x, 8'h00);
    check(host_rdata, exp_rd(x));
  endtask : hrd
  task automatic hprog(input logic [15:0] x, input logic [7:0] d);
    host(fcs_pkg::FCS_OP_PROGRAM, x, d);
    if (unlock == `FCS_UNLOCK_ENABLE && !(m_prot && mode == fcs_pkg::FCS_MODE_SERIAL)) mem[x] = mem[x] & d;
  endtask : hprog
  task automatic herase(input bit chip, input logic [15:0] x);
    host(chip ? fcs_pkg::FCS_OP_CHIP_ERASE : fcs_pkg::FCS_OP_SECTOR_ERASE, x, 8'h00);
    if (unlock == `FCS_UNLOCK_ENABLE && (chip || mode != fcs_pkg::FCS_MODE_PARALLEL)) begin
      for (int i = 32'h0000F000; i < 32'h00010000; i++) mem[i] = 8'hFF;
      if (chip) m_prot = 1'b0;
    end
  endtask : herase
  task automatic bw(input logic [15:0] x, input logic [7:0] d);
    bus_b.req = 1'b1;
    bus_b.we = 1'b1;
    bus_b.addr = x;
    bus_b.wdata = d;
    @(negedge i_sys_clk);
  endtask : bw
  // Upper nibbles differ from the host's so only the low 12 bits can match
  task automatic bunlock(input logic [7:0] c);
    bw(16'h3555, 8'hAA);
    bw(16'h7AAA, 8'h55);
    bw(16'h1555, c);
  endtask : bunlock
  task automatic bidle(input int n);
    bus_b.req = 1'b0;
    for (int i = 0; i < n && (i == 0 || busy_b === 1'b1); i++) @(negedge i_sys_clk);
  endtask : bidle
  task automatic brd(input logic [15:0] x, input logic [7:0] m, input logic [7:0] exp);
    bus_b.req = 1'b1;
    bus_b.we = 1'b0;
    bus_b.addr = x;
    @(negedge i_sys_clk);
    bus_b.req = 1'b0;
    @(negedge i_sys_clk);
    check(bus_b.rdata & m, exp);
  endtask : brd
  initial begin
    #400000;
    check(8'h00, 8'hFF);
    test_done();
  end
  initial begin
    {bus_b.req, bus_b.we, bus_b.addr, bus_b.wdata} = '0;
    repeat (8) @(negedge i_sys_clk);
    i_reset_n = 1'b1;
    unlock = `FCS_UNLOCK_ENABLE;
    herase(1'b1, 16'hF555);
    for (int i = 0; i < 6; i++) begin
      a = rnd();
      a[15:12] = 4'hF;
      hprog(a, 8'(rnd()));
      hrd(a);
    end
    unlock = `FCS_UNLOCK_RESET;
    hprog(a, 8'h00);
    hrd(a);
    unlock = `FCS_UNLOCK_ENABLE;
    hrd(16'h8000);
    host(fcs_pkg::FCS_OP_ID_ENTRY, 16'h0000, 8'h00);
    m_id = 1'b1;
    check({7'h00, idm}, 8'h01);
    foreach (id_adr[k]) hrd(id_adr[k]);
    host(fcs_pkg::FCS_OP_PROTECT, `FCS_PROTECT_ADR, `FCS_PROTECT_DAT);
    host(fcs_pkg::FCS_OP_ID_EXIT, 16'h0000, 8'h00);
    m_id = 1'b0;
    m_prot = 1'b1;
    check({6'h00, idm, prot}, 8'h01);
    hrd(a);
    host(fcs_pkg::FCS_OP_ID_ENTRY, 16'h0000, 8'h00);
    m_id = 1'b1;
    hrd(`FCS_PROTECT_ADR);
    host(fcs_pkg::FCS_OP_ID_EXIT, 16'h0000, 8'h00);
    m_id = 1'b0;
    mode = fcs_pkg::FCS_MODE_PARALLEL;
    hrd(a);
    herase(1'b0, a);
    mode = fcs_pkg::FCS_MODE_SERIAL;
    hprog(a, 8'h00);
    mode = fcs_pkg::FCS_MODE_MCU;
    hrd(a);
    herase(1'b0, 16'hF123);
    check({7'h00, prot}, 8'h01);
    hrd(a);
    herase(1'b1, 16'hF555);
    check({7'h00, prot}, 8'h00);
    bunlock(8'h80);
    bw(16'h3555, 8'hAA);
    bw(16'h5AAA, 8'h55);
    bw(16'h2555, 8'h10);
    bidle(1);
    brd(16'hF000, 8'h40, 8'h40);
    brd(16'hF001, 8'h40, 8'h00);
    bunlock(8'hA0);
    bw(16'hF030, 8'h00);
    bidle(ERASE_CYCLES + 10);
    brd(16'hF030, 8'hFF, 8'hFF);
    bw(16'hF555, 8'hAA);
    bw(16'hF123, 8'h55);
    bw(16'hF555, 8'hA0);
    bw(16'hF010, 8'h00);
    bidle(PROG_CYCLES + 10);
    brd(16'hF010, 8'hFF, 8'hFF);
    bunlock(8'hA0);
    bw(16'hF020, 8'h3C);
    bidle(1);
    bidle(PROG_CYCLES + 10);
    brd(16'hF020, 8'hFF, 8'h3C);
    test_done();
  end
endmodule : tb_flash_command_sequencer
